//--- dtm_pkg.sv
// package: register map, field layouts and constants of the dual timer and capture timer
package dtm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_A = 8'h04;
  localparam logic [7:0] ADDR_CNT_B = 8'h08;
  localparam logic [7:0] ADDR_TM3_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_TM3_CNT = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;

  // timer control word: general timer a in bits 5:0, timer b in bits 13:8
  localparam int CFG_W = 6;
  localparam int CFG_A_LSB = 0;
  localparam int CFG_B_LSB = 8;
  localparam int TM3_CFG_W = 7;
  localparam int CNT_W = 16;

  localparam logic [1:0] MODE_PRESCALED = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD8 = 2'h2;

  typedef struct packed {
    logic timebase_select;
    logic run_control;
    logic gate_qualify;
    logic source_select;
    logic [1:0] mode;
  } dtm_gt_cfg_t;

  typedef struct packed {
    logic timebase_select;
    logic down_count_enable;
    logic capture_auto_clear;
    logic ext_trigger_enable;
    logic capture_reload_select;
    logic source_select;
    logic third_timer_run;
  } dtm_tm3_cfg_t;

  typedef struct packed {
    logic [7:0] count_high_byte;
    logic [7:0] count_low_byte;
  } dtm_cnt_t;

  typedef struct packed {
    logic ovf;
    dtm_cnt_t cnt;
  } dtm_step_t;

  localparam int LOW5_MSB = 4;
  localparam logic [4:0] LOW5_MAX = 5'h1F;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;

  // status / mask bit positions
  localparam int STATUS_W = 4;
  localparam int ST_OVF_A = 0;
  localparam int ST_OVF_B = 1;
  localparam int ST_OVF_3 = 2;
  localparam int ST_TRIG = 3;

  // time base: one mod-12 counter gives both the /12 and the /4 tick
  localparam logic [3:0] DIV_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  localparam int NPINS = 6;
  localparam int PIN_CNT_A = 0;
  localparam int PIN_CNT_B = 1;
  localparam int PIN_IRQ_A = 2;
  localparam int PIN_IRQ_B = 3;
  localparam int PIN_TM3_CNT = 4;
  localparam int PIN_TRIG = 5;
endpackage : dtm_pkg

//--- dtm_pin_sync.sv
// module: two-flop synchronisers and falling-edge detect for the timer pins
`timescale 1ns/10ps
`default_nettype none
module dtm_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [dtm_pkg::NPINS-1:0] pin_in,
  output logic [dtm_pkg::NPINS-1:0] level,
  output logic [dtm_pkg::NPINS-1:0] fall
);
  logic [dtm_pkg::NPINS-1:0] meta_reg;
  logic [dtm_pkg::NPINS-1:0] sync_reg;
  logic [dtm_pkg::NPINS-1:0] prev_reg;

  // meta_reg feeds sync_reg only; edges come from the two settled stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign fall = prev_reg & ~sync_reg;
endmodule : dtm_pin_sync
`default_nettype wire

//--- dtm_top.sv
// module: two general timers and a capture/reload timer behind an apb slave
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dtm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtm_pkg::ADDR_W-1:0] paddr,
  input wire logic [dtm_pkg::DATA_W-1:0] pwdata,
  output logic [dtm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_pin_a,
  input wire logic count_input_pin_b,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic third_timer_count_pin,
  input wire logic ext_trigger_pin,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [dtm_pkg::NPINS-1:0] pin_lvl;
  logic [dtm_pkg::NPINS-1:0] pin_fall;

  dtm_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({ext_trigger_pin, third_timer_count_pin, ext_irq_pin_b, ext_irq_pin_a,
             count_input_pin_b, count_input_pin_a}),
    .level(pin_lvl),
    .fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic gt_event(dtm_pkg::dtm_gt_cfg_t c, logic gate_lvl, logic fall,
                                    logic t12, logic t4);
    gt_event = c.run_control && (!c.gate_qualify || gate_lvl) &&
               (c.source_select ? fall : (c.timebase_select ? t4 : t12));
  endfunction : gt_event

  function automatic dtm_pkg::dtm_step_t gt_step(dtm_pkg::dtm_cnt_t c, logic [1:0] mode);
    dtm_pkg::dtm_step_t r;
    r.ovf = 1'b0;
    r.cnt = c;
    case (mode)
      dtm_pkg::MODE_PRESCALED: begin
        // bits 7:5 of the low byte are left as software wrote them
        if (c.count_low_byte[dtm_pkg::LOW5_MSB:0] == dtm_pkg::LOW5_MAX) begin
          r.cnt.count_low_byte[dtm_pkg::LOW5_MSB:0] = '0;
          r.cnt.count_high_byte = c.count_high_byte + 8'h01;
          r.ovf = (c.count_high_byte == dtm_pkg::BYTE_MAX);
        end else begin
          r.cnt.count_low_byte[dtm_pkg::LOW5_MSB:0] =
            c.count_low_byte[dtm_pkg::LOW5_MSB:0] + 5'h01;
        end
      end
      dtm_pkg::MODE_16BIT: begin
        r.cnt = c + 16'h0001;
        r.ovf = (c == dtm_pkg::WORD_MAX);
      end
      dtm_pkg::MODE_RELOAD8: begin
        if (c.count_low_byte == dtm_pkg::BYTE_MAX) begin
          r.cnt.count_low_byte = c.count_high_byte;
          r.ovf = 1'b1;
        end else begin
          r.cnt.count_low_byte = c.count_low_byte + 8'h01;
        end
      end
      default: begin
        // the fourth mode is not provided: the count holds
        r.cnt = c;
      end
    endcase
    return r;
  endfunction : gt_step

  ////////////////////////////////////////////////////////////////////////////
  // time base
  logic [3:0] div_reg;
  logic tick12;
  logic tick4;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (div_reg == dtm_pkg::DIV_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  assign tick12 = (div_reg == dtm_pkg::DIV_LAST);
  assign tick4 = (div_reg[1:0] == dtm_pkg::DIV4_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, answer prepared in the setup cycle
  logic pready_reg;
  logic pslverr_reg;
  logic [dtm_pkg::DATA_W-1:0] prdata_reg;
  logic [dtm_pkg::DATA_W-1:0] rdata_next;
  logic hit_next;
  logic wr;
  logic wr_ctrl, wr_cnt_a, wr_cnt_b, wr_tm3_ctrl, wr_tm3_cnt, wr_cap, wr_status, wr_mask;

  dtm_pkg::dtm_gt_cfg_t cfg_a_reg;
  dtm_pkg::dtm_gt_cfg_t cfg_b_reg;
  dtm_pkg::dtm_tm3_cfg_t tm3_cfg_reg;
  dtm_pkg::dtm_cnt_t cnt_a_reg;
  dtm_pkg::dtm_cnt_t cnt_b_reg;
  dtm_pkg::dtm_cnt_t cnt3_reg;
  dtm_pkg::dtm_cnt_t cap_reg;
  logic [dtm_pkg::STATUS_W-1:0] status_reg;
  logic [dtm_pkg::STATUS_W-1:0] status_next;
  logic [dtm_pkg::STATUS_W-1:0] mask_reg;
  logic irq_reg;

  always_comb begin
    rdata_next = '0;
    hit_next = 1'b1;
    case (paddr)
      dtm_pkg::ADDR_CTRL: begin
        rdata_next[dtm_pkg::CFG_A_LSB +: dtm_pkg::CFG_W] = cfg_a_reg;
        rdata_next[dtm_pkg::CFG_B_LSB +: dtm_pkg::CFG_W] = cfg_b_reg;
      end
      dtm_pkg::ADDR_CNT_A: rdata_next[dtm_pkg::CNT_W-1:0] = cnt_a_reg;
      dtm_pkg::ADDR_CNT_B: rdata_next[dtm_pkg::CNT_W-1:0] = cnt_b_reg;
      dtm_pkg::ADDR_TM3_CTRL: rdata_next[dtm_pkg::TM3_CFG_W-1:0] = tm3_cfg_reg;
      dtm_pkg::ADDR_TM3_CNT: rdata_next[dtm_pkg::CNT_W-1:0] = cnt3_reg;
      dtm_pkg::ADDR_CAPTURE: rdata_next[dtm_pkg::CNT_W-1:0] = cap_reg;
      dtm_pkg::ADDR_STATUS: rdata_next[dtm_pkg::STATUS_W-1:0] = status_reg;
      dtm_pkg::ADDR_MASK: rdata_next[dtm_pkg::STATUS_W-1:0] = mask_reg;
      default: hit_next = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (psel && !penable) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !hit_next;
      prdata_reg <= pwrite ? '0 : rdata_next;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  assign wr = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign wr_ctrl = wr && (paddr == dtm_pkg::ADDR_CTRL);
  assign wr_cnt_a = wr && (paddr == dtm_pkg::ADDR_CNT_A);
  assign wr_cnt_b = wr && (paddr == dtm_pkg::ADDR_CNT_B);
  assign wr_tm3_ctrl = wr && (paddr == dtm_pkg::ADDR_TM3_CTRL);
  assign wr_tm3_cnt = wr && (paddr == dtm_pkg::ADDR_TM3_CNT);
  assign wr_cap = wr && (paddr == dtm_pkg::ADDR_CAPTURE);
  assign wr_status = wr && (paddr == dtm_pkg::ADDR_STATUS);
  assign wr_mask = wr && (paddr == dtm_pkg::ADDR_MASK);

  // control state all clears on reset, so every timer starts stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_reg <= '0;
      cfg_b_reg <= '0;
      tm3_cfg_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        cfg_a_reg <= pwdata[dtm_pkg::CFG_A_LSB +: dtm_pkg::CFG_W];
        cfg_b_reg <= pwdata[dtm_pkg::CFG_B_LSB +: dtm_pkg::CFG_W];
      end
      if (wr_tm3_ctrl) begin
        tm3_cfg_reg <= pwdata[dtm_pkg::TM3_CFG_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= pwdata[dtm_pkg::STATUS_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general timers; a software write to a count wins over a count event
  logic ev_a, ev_b;
  dtm_pkg::dtm_step_t step_a, step_b;

  assign ev_a = gt_event(cfg_a_reg, pin_lvl[dtm_pkg::PIN_IRQ_A], pin_fall[dtm_pkg::PIN_CNT_A],
                         tick12, tick4);
  assign ev_b = gt_event(cfg_b_reg, pin_lvl[dtm_pkg::PIN_IRQ_B], pin_fall[dtm_pkg::PIN_CNT_B],
                         tick12, tick4);
  assign step_a = gt_step(cnt_a_reg, cfg_a_reg.mode);
  assign step_b = gt_step(cnt_b_reg, cfg_b_reg.mode);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_a_reg <= '0;
      cnt_b_reg <= '0;
    end else begin
      if (wr_cnt_a) begin
        cnt_a_reg <= pwdata[dtm_pkg::CNT_W-1:0];
      end else if (ev_a) begin
        cnt_a_reg <= step_a.cnt;
      end
      if (wr_cnt_b) begin
        cnt_b_reg <= pwdata[dtm_pkg::CNT_W-1:0];
      end else if (ev_b) begin
        cnt_b_reg <= step_b.cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // third timer: capture or up-counting reload; down counting is not provided,
  // so with down_count_enable set in reload mode the count simply wraps
  logic ev3, trig3, ovf3, cap_ev, reload_ev;

  assign ev3 = tm3_cfg_reg.third_timer_run &&
               (tm3_cfg_reg.source_select ? pin_fall[dtm_pkg::PIN_TM3_CNT] :
                (tm3_cfg_reg.timebase_select ? tick4 : tick12));
  assign trig3 = tm3_cfg_reg.ext_trigger_enable && pin_fall[dtm_pkg::PIN_TRIG];
  assign ovf3 = ev3 && (cnt3_reg == dtm_pkg::WORD_MAX);
  assign cap_ev = trig3 && tm3_cfg_reg.capture_reload_select;
  assign reload_ev = !tm3_cfg_reg.capture_reload_select && !tm3_cfg_reg.down_count_enable &&
                     (ovf3 || trig3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt3_reg <= '0;
    end else if (wr_tm3_cnt) begin
      cnt3_reg <= pwdata[dtm_pkg::CNT_W-1:0];
    end else if (cap_ev && tm3_cfg_reg.capture_auto_clear) begin
      cnt3_reg <= '0;
    end else if (reload_ev) begin
      cnt3_reg <= cap_reg;
    end else if (ev3) begin
      cnt3_reg <= cnt3_reg + 16'h0001;
    end
  end

  // a capture that lands on a software write keeps the captured value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= '0;
    end else if (cap_ev) begin
      cap_reg <= cnt3_reg;
    end else if (wr_cap) begin
      cap_reg <= pwdata[dtm_pkg::CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, write one to clear; a new event in the clearing cycle stays
  logic [dtm_pkg::STATUS_W-1:0] set_vec;
  logic [dtm_pkg::STATUS_W-1:0] clr_vec;

  always_comb begin
    set_vec = '0;
    set_vec[dtm_pkg::ST_OVF_A] = ev_a && step_a.ovf && !wr_cnt_a;
    set_vec[dtm_pkg::ST_OVF_B] = ev_b && step_b.ovf && !wr_cnt_b;
    set_vec[dtm_pkg::ST_OVF_3] = ovf3 && !wr_tm3_cnt;
    set_vec[dtm_pkg::ST_TRIG] = cap_ev || (trig3 && !tm3_cfg_reg.down_count_enable);
    clr_vec = wr_status ? pwdata[dtm_pkg::STATUS_W-1:0] : '0;
    status_next = (status_reg & ~clr_vec) | set_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & (wr_mask ? pwdata[dtm_pkg::STATUS_W-1:0] : mask_reg));
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_tb12_period;
    @(posedge pclk) disable iff (!presetn) tick12 |-> ##12 tick12;
  endproperty
  a_tb12_period: assert property (p_tb12_period) else $error("divide-by-12 tick off");

  property p_gate_hold;
    @(posedge pclk) disable iff (!presetn)
      (!cfg_a_reg.run_control || (cfg_a_reg.gate_qualify && !pin_lvl[dtm_pkg::PIN_IRQ_A]))
      && !wr_cnt_a |=> $stable(cnt_a_reg);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("timer a counted while gated");

  property p_presc_carry;
    @(posedge pclk) disable iff (!presetn)
      ev_b && !wr_cnt_b && cfg_b_reg.mode == dtm_pkg::MODE_PRESCALED &&
      cnt_b_reg.count_low_byte[dtm_pkg::LOW5_MSB:0] == dtm_pkg::LOW5_MAX
      |=> cnt_b_reg.count_high_byte == $past(cnt_b_reg.count_high_byte) + 8'h01;
  endproperty
  a_presc_carry: assert property (p_presc_carry) else $error("prescaled carry lost");

  property p_wrap16;
    @(posedge pclk) disable iff (!presetn)
      ev_a && !wr_cnt_a && cfg_a_reg.mode == dtm_pkg::MODE_16BIT &&
      cnt_a_reg == dtm_pkg::WORD_MAX |=> cnt_a_reg == '0 && status_reg[dtm_pkg::ST_OVF_A];
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap not flagged");

  property p_reload8;
    @(posedge pclk) disable iff (!presetn)
      ev_a && !wr_cnt_a && cfg_a_reg.mode == dtm_pkg::MODE_RELOAD8 &&
      cnt_a_reg.count_low_byte == dtm_pkg::BYTE_MAX
      |=> cnt_a_reg.count_low_byte == $past(cnt_a_reg.count_high_byte) &&
          $stable(cnt_a_reg.count_high_byte);
  endproperty
  a_reload8: assert property (p_reload8) else $error("8-bit reload wrong");

  property p_run3_hold;
    @(posedge pclk) disable iff (!presetn)
      !tm3_cfg_reg.third_timer_run && !trig3 && !wr_tm3_cnt |=> $stable(cnt3_reg);
  endproperty
  a_run3_hold: assert property (p_run3_hold) else $error("third timer ran while stopped");

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      cap_ev |=> cap_reg == $past(cnt3_reg) && status_reg[dtm_pkg::ST_TRIG];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_auto_clear;
    @(posedge pclk) disable iff (!presetn)
      cap_ev && tm3_cfg_reg.capture_auto_clear && !wr_tm3_cnt |=> cnt3_reg == '0;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("count not cleared");

  property p_reload16;
    @(posedge pclk) disable iff (!presetn)
      reload_ev && !wr_tm3_cnt |=> cnt3_reg == $past(cap_reg);
  endproperty
  a_reload16: assert property (p_reload16) else $error("16-bit reload wrong");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn) irq == |(status_reg & mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq disagrees with flags");
endmodule : dtm_top
`default_nettype wire

//--- dtm_pins_model.sv
// file: behavioural driver of the count, gate and trigger pins
`timescale 1ns/10ps
`default_nettype none
module dtm_pins_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [dtm_pkg::NPINS-1:0] fire,
  input wire logic [1:0] gate,
  output logic [dtm_pkg::NPINS-1:0] pins
);
  logic [1:0] low_cnt [dtm_pkg::NPINS];

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < dtm_pkg::NPINS; i++) low_cnt[i] <= 2'h0;
    end else begin
      for (int i = 0; i < dtm_pkg::NPINS; i++) begin
        if (fire[i]) begin
          low_cnt[i] <= 2'h2;
        end else if (low_cnt[i] != 2'h0) begin
          low_cnt[i] <= low_cnt[i] - 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // two cycles low, then high again, so a synchronised sampler cannot miss a fall
  always_comb begin
    for (int i = 0; i < dtm_pkg::NPINS; i++) pins[i] = (low_cnt[i] == 2'h0);
    pins[dtm_pkg::PIN_IRQ_A] = gate[0];
    pins[dtm_pkg::PIN_IRQ_B] = gate[1];
  end
endmodule : dtm_pins_model
`default_nettype wire

//--- dtm_top_test.sv
// file: self-checking testbench of the dual timer and capture timer
`timescale 1ns/10ps
`default_nettype none
module dtm_top_test;
  localparam int SPAN = 48;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [5:0] fire;
  logic [1:0] gate;
  logic [5:0] pins;
  logic [32:0] notes [$];
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hE5094BEC;

  always #20 pclk = ~pclk;

  dtm_pins_model i_pins (.pclk(pclk), .presetn(presetn), .fire(fire), .gate(gate), .pins(pins));
  dtm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_pin_a(pins[0]), .count_input_pin_b(pins[1]),
    .ext_irq_pin_a(pins[2]), .ext_irq_pin_b(pins[3]), .third_timer_count_pin(pins[4]),
    .ext_trigger_pin(pins[5]), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // every transfer leaves a note {pslverr, prdata}; writes expect zero data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] exp);
    notes.push_back(exp);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave needs; only the bench timeout ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h000000000);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, {1'b0, e});
  endtask : rd

  task automatic pulse(input int i);
    fire[i] <= 1'b1;
    @(posedge pclk);
    fire[i] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse

  task automatic sweep();
    for (int k = 0; k < 8; k++) rd(8'(4 * k), 32'h00000000);
    chk({32'h00000000, irq}, 33'h000000000);
    apb(1'b0, 8'h20, 32'h00000000, {1'b1, 32'h00000000});
    apb(1'b1, 8'h24, 32'hFFFFFFFF, {1'b1, 32'h00000000});
    rd(dtm_pkg::ADDR_MASK, 32'h00000000);
    $display("test reset sweep done");
  endtask : sweep

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        n_fail++;
        $display("BAD at %0t got %h expected %h", $time, {pslverr, prdata}, 33'h000000000);
      end else begin
        chk({pslverr, prdata}, notes.pop_front());
      end
    end
  end

  // the whole sequence needs about 400 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    fire = 6'h00;
    gate = 2'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sweep();
    wr(dtm_pkg::ADDR_CNT_A, 32'h0000FFFE);
    wr(dtm_pkg::ADDR_MASK, 32'h00000001);
    wr(dtm_pkg::ADDR_CTRL, 32'h00000015);
    pulse(dtm_pkg::PIN_CNT_A);
    pulse(dtm_pkg::PIN_CNT_A);
    rd(dtm_pkg::ADDR_CNT_A, 32'h00000000);
    rd(dtm_pkg::ADDR_STATUS, 32'h00000001);
    chk({32'h00000000, irq}, 33'h000000001);
    wr(dtm_pkg::ADDR_STATUS, 32'h00000001);
    chk({32'h00000000, irq}, 33'h000000000);
    $display("test wide mode done");
    wr(dtm_pkg::ADDR_CNT_B, 32'h0000FFFF);
    wr(dtm_pkg::ADDR_CTRL, 32'h00001400);
    pulse(dtm_pkg::PIN_CNT_B);
    rd(dtm_pkg::ADDR_CNT_B, 32'h000000E0);
    rd(dtm_pkg::ADDR_STATUS, 32'h00000002);
    chk({32'h00000000, irq}, 33'h000000000);
    wr(dtm_pkg::ADDR_STATUS, 32'h00000002);
    $display("test prescaled done");
    wr(dtm_pkg::ADDR_CNT_A, 32'h00000000);
    wr(dtm_pkg::ADDR_CTRL, 32'h0000001D);
    pulse(dtm_pkg::PIN_CNT_A);
    rd(dtm_pkg::ADDR_CNT_A, 32'h00000000);
    gate <= 2'h1;
    pulse(dtm_pkg::PIN_CNT_A);
    rd(dtm_pkg::ADDR_CNT_A, 32'h00000001);
    $display("test gate done");
    wr(dtm_pkg::ADDR_CNT_A, 32'h000080FF);
    wr(dtm_pkg::ADDR_CTRL, 32'h00000016);
    pulse(dtm_pkg::PIN_CNT_A);
    rd(dtm_pkg::ADDR_CNT_A, 32'h00008080);
    rd(dtm_pkg::ADDR_STATUS, 32'h00000001);
    wr(dtm_pkg::ADDR_STATUS, 32'h00000001);
    $display("test byte reload done");
    // start and stop writes keep equal spacing, so each timer sees SPAN edges whatever
    // the phase of the shared divider
    wr(dtm_pkg::ADDR_CNT_A, 32'h00000000);
    wr(dtm_pkg::ADDR_CNT_B, 32'h00000000);
    wr(dtm_pkg::ADDR_TM3_CNT, 32'h00000000);
    wr(dtm_pkg::ADDR_CTRL, 32'h00003111);
    wr(dtm_pkg::ADDR_TM3_CTRL, 32'h00000001);
    repeat (SPAN - 6) @(posedge pclk);
    wr(dtm_pkg::ADDR_CTRL, 32'h00000000);
    wr(dtm_pkg::ADDR_TM3_CTRL, 32'h00000000);
    rd(dtm_pkg::ADDR_CNT_A, 32'(SPAN / 12));
    rd(dtm_pkg::ADDR_CNT_B, 32'(SPAN / 4));
    rd(dtm_pkg::ADDR_TM3_CNT, 32'(SPAN / 12));
    $display("test time base done");
    wr(dtm_pkg::ADDR_TM3_CNT, 32'h0000FFFF);
    wr(dtm_pkg::ADDR_TM3_CTRL, 32'h0000000F);
    pulse(dtm_pkg::PIN_TM3_CNT);
    rd(dtm_pkg::ADDR_TM3_CNT, 32'h00000000);
    rd(dtm_pkg::ADDR_STATUS, 32'h00000004);
    pulse(dtm_pkg::PIN_TM3_CNT);
    pulse(dtm_pkg::PIN_TRIG);
    rd(dtm_pkg::ADDR_CAPTURE, 32'h00000001);
    rd(dtm_pkg::ADDR_STATUS, 32'h0000000C);
    wr(dtm_pkg::ADDR_STATUS, 32'h0000000C);
    wr(dtm_pkg::ADDR_TM3_CTRL, 32'h0000001F);
    pulse(dtm_pkg::PIN_TM3_CNT);
    pulse(dtm_pkg::PIN_TRIG);
    rd(dtm_pkg::ADDR_CAPTURE, 32'h00000002);
    rd(dtm_pkg::ADDR_TM3_CNT, 32'h00000000);
    wr(dtm_pkg::ADDR_STATUS, 32'h00000008);
    $display("test capture done");
    seed = lfsr(seed);
    wr(dtm_pkg::ADDR_CAPTURE, {16'h0000, seed[15:0]});
    wr(dtm_pkg::ADDR_TM3_CNT, 32'h0000FFFF);
    wr(dtm_pkg::ADDR_MASK, 32'h0000000F);
    wr(dtm_pkg::ADDR_TM3_CTRL, 32'h0000000B);
    pulse(dtm_pkg::PIN_TM3_CNT);
    rd(dtm_pkg::ADDR_TM3_CNT, {16'h0000, seed[15:0]});
    rd(dtm_pkg::ADDR_STATUS, 32'h00000004);
    wr(dtm_pkg::ADDR_STATUS, 32'h00000004);
    wr(dtm_pkg::ADDR_TM3_CNT, 32'h00000050);
    pulse(dtm_pkg::PIN_TRIG);
    rd(dtm_pkg::ADDR_TM3_CNT, {16'h0000, seed[15:0]});
    rd(dtm_pkg::ADDR_STATUS, 32'h00000008);
    chk({32'h00000000, irq}, 33'h000000001);
    $display("test word reload done");
    // down counting is not provided: with it selected the trigger is ignored, the count wraps
    wr(dtm_pkg::ADDR_STATUS, 32'h00000008);
    wr(dtm_pkg::ADDR_TM3_CTRL, 32'h0000002B);
    wr(dtm_pkg::ADDR_TM3_CNT, 32'h0000FFFF);
    pulse(dtm_pkg::PIN_TRIG);
    rd(dtm_pkg::ADDR_TM3_CNT, 32'h0000FFFF);
    rd(dtm_pkg::ADDR_STATUS, 32'h00000000);
    pulse(dtm_pkg::PIN_TM3_CNT);
    rd(dtm_pkg::ADDR_TM3_CNT, 32'h00000000);
    rd(dtm_pkg::ADDR_STATUS, 32'h00000004);
    chk({32'h00000000, irq}, 33'h000000001);
    $display("test down-count select done");
    // reset in mid-run with the third timer still counting and the interrupt high
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sweep();
    finish_test();
  end
endmodule : dtm_top_test
`default_nettype wire
